/* File: core/drive_control_source_selector.v */
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "drive_ctl_defines.vh"
module drive_control_source_selector #(
  parameter DW = 16
) (
  input wire clk,
  input wire rst,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [4:0] di,
  input wire [DW-1:0] ai1_ref,
  input wire [DW-1:0] ai2_ref,
  input wire [DW-1:0] pi_ref,
  input wire kpd_start,
  input wire kpd_stop,
  input wire kpd_up,
  input wire kpd_down,
  input wire opt_present,
  input wire opt_run,
  input wire opt_rev,
  input wire [DW-1:0] opt_ref,
  input wire mb_run,
  input wire mb_rev,
  input wire [DW-1:0] mb_ref,
  input wire mst_run,
  input wire mst_rev,
  input wire [DW-1:0] mst_ref,
  input wire can_run,
  input wire can_rev,
  input wire [DW-1:0] can_ref,
  output reg run_cmd,
  output reg reverse_cmd,
  output reg [DW-1:0] speed_ref,
  output reg [5:0] cmd_src,
  output reg [6:0] ref_src,
  output reg op_blocked,
  output reg ext_menu,
  output reg adv_menu,
  output reg [19:0] di_func,
  output reg [7:0] ai_func
);
  reg [2:0] src_r;
  reg [4:0] mac_r;
  reg auto_r;
  reg [1:0] ksb_r;
  reg [15:0] code_r;
  reg [15:0] lvl1_r;
  reg [15:0] lvl2_r;
  reg [DW-1:0] kref_r;
  reg [15:0] scale_r;
  reg kpd_run_r;
  reg kpd_rev_r;
  reg auto_blk_r;
  reg [4:0] di_prev_r;

  // one-hot speed reference select; out-of-range acts as terminal
  function [6:0] ref_onehot;
    input [2:0] m;
    input present;
    begin
      ref_onehot = 7'h00;
      case (m)
        `M_KPD1, `M_KPD2: ref_onehot[`S_KPD] = 1'b1;
        `M_PI: ref_onehot[`S_PI] = 1'b1;
        `M_FB: begin
          if (present) begin
            ref_onehot[`S_OPT] = 1'b1;
          end else begin
            ref_onehot[`S_MB] = 1'b1;
          end
        end
        `M_SLV: ref_onehot[`S_MST] = 1'b1;
        `M_CAN: ref_onehot[`S_CAN] = 1'b1;
        default: ref_onehot[`S_AI] = 1'b1;
      endcase
    end
  endfunction

  // true when any input with the given function is at level one
  function any_func;
    input [19:0] f;
    input [4:0] lvl;
    input [3:0] code;
    integer i;
    begin
      any_func = 1'b0;
      for (i = 0; i < 5; i = i + 1) begin
        if (f[4*i +: 4] == code && lvl[i]) begin
          any_func = 1'b1;
        end
      end
    end
  endfunction

  // saturating add/subtract for the motorised pot
  function [DW-1:0] step_ref;
    input [DW-1:0] v;
    input up;
    reg [DW:0] s;
    begin
      s = {1'b0, v};
      if (up) begin
        s = s + {1'b0, `KREF_STEP};
        step_ref = s[DW] ? {DW{1'b1}} : s[DW-1:0];
      end else begin
        step_ref = (v < `KREF_STEP) ? {DW{1'b0}} : v - `KREF_STEP;
      end
    end
  endfunction

  // terminal speed reference: analog 2 while its select input is closed
  function [DW-1:0] term_ref;
    input sel2;
    input [DW-1:0] a1;
    input [DW-1:0] a2;
    begin
      term_ref = sel2 ? a2 : a1;
    end
  endfunction

  wire [2:0] mode = (src_r > `M_CAN) ? `M_TERM : src_r;
  wire [19:0] dif;
  wire [7:0] aif;

  input_macro_table input_macro_table_i (
    .macro(mac_r),
    .mode(mode),
    .di_func(dif),
    .ai_func(aif)
  );

  wire [6:0] sel = ref_onehot(mode, opt_present);
  wire [5:0] csel = {sel[`S_CAN], sel[`S_MST], sel[`S_MB],
                     sel[`S_OPT], sel[`S_KPD],
                     sel[`S_AI] | sel[`S_PI]};

  wire en_in = di[0];
  wire t_fwd = any_func(dif, di, `F_RUN_FWD);
  wire t_rev = any_func(dif, di, `F_RUN_REV);
  wire t_dir = any_func(dif, di, `F_DIR_REV);
  wire stop_open = any_func(dif, ~di, `F_STOP_NC);
  wire trip_open = any_func(dif, ~di, `F_TRIP_NC);
  wire t_ai2 = any_func(dif, di, `F_AI2_SEL);
  wire inc_edge = any_func(dif, di & ~di_prev_r, `F_INC);
  wire dec_edge = any_func(dif, di & ~di_prev_r, `F_DEC);
  wire term_run = (t_fwd | t_rev) & ~stop_open;
  wire term_rev = t_rev | t_dir;
  wire kpd_mode = sel[`S_KPD];
  wire direct = ksb_r[0];

  // digital input 1 gates fieldbus, slave and CAN operation
  wire en_gate = (mode == `M_FB || mode == `M_SLV ||
                  mode == `M_CAN) & ~en_in;
  wire blocked = en_gate | trip_open;

  reg req_run;
  reg req_rev;
  reg [DW-1:0] req_ref;
  reg [DW+15:0] prod;
  always @* begin
    req_run = term_run;
    req_rev = term_rev;
    req_ref = term_ref(t_ai2, ai1_ref, ai2_ref);
    prod = mst_ref * scale_r;
    case (1'b1)
      sel[`S_KPD]: begin
        req_run = kpd_run_r;
        req_rev = kpd_rev_r;
        req_ref = kref_r;
      end
      sel[`S_PI]: req_ref = pi_ref;
      sel[`S_OPT]: begin
        req_run = opt_run;
        req_rev = opt_rev;
        req_ref = opt_ref;
      end
      sel[`S_MB]: begin
        req_run = mb_run;
        req_rev = mb_rev;
        req_ref = mb_ref;
      end
      sel[`S_MST]: begin
        req_run = mst_run;
        req_rev = mst_rev;
        // scale is 8.8 fixed point; result saturates
        req_ref = (|prod[DW+15:DW+8]) ? {DW{1'b1}} : prod[DW+7:8];
      end
      sel[`S_CAN]: begin
        req_run = can_run;
        req_rev = can_rev;
        req_ref = can_ref;
      end
      default: req_ref = term_ref(t_ai2, ai1_ref, ai2_ref);
    endcase
  end

  wire run_nxt = req_run & ~blocked & ~auto_blk_r;
  wire kpd_start_ev = kpd_mode & en_in & ~kpd_run_r &
                      (direct | kpd_start);

  // apb: zero-wait; data and error are captured in the setup cycle
  wire setup = psel & ~penable;
  wire wr = psel & penable & pready & pwrite & ~pslverr;
  wire mapped = (paddr == `A_CFG) || (paddr == `A_CODE) ||
                (paddr == `A_LVL1) || (paddr == `A_LVL2) ||
                (paddr == `A_KREF) || (paddr == `A_SCALE) ||
                (paddr == `A_STAT) || (paddr == `A_TMAP);

  reg [31:0] rd;
  always @* begin
    rd = 32'h0000_0000;
    case (paddr)
      `A_CFG: begin
        rd[`CFG_SRC_LSB +: 3] = src_r;
        rd[`CFG_MAC_LSB +: 5] = mac_r;
        rd[`CFG_AUTO_BIT] = auto_r;
        rd[`CFG_DIRECT_BIT] = ksb_r[0];
        rd[`CFG_KEEP_BIT] = ksb_r[1];
      end
      `A_CODE: rd[15:0] = code_r;
      `A_LVL1: rd[15:0] = lvl1_r;
      `A_LVL2: rd[15:0] = lvl2_r;
      `A_KREF: rd[DW-1:0] = kref_r;
      `A_SCALE: rd[15:0] = scale_r;
      `A_STAT: rd = {10'h000, auto_blk_r, adv_menu, ext_menu,
                     op_blocked, reverse_cmd, run_cmd, 2'h0,
                     cmd_src, 1'b0, ref_src};
      `A_TMAP: rd = {4'h0, ai_func, di_func};
      default: rd = 32'h0000_0000;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= rd;
      end
    end
  end

  // settings and keypad state
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      src_r <= `SRC_RST;
      mac_r <= `MAC_RST;
      auto_r <= `AUTO_RST;
      ksb_r <= `KSB_RST;
      code_r <= `CODE_RST;
      lvl1_r <= `LVL1_RST;
      lvl2_r <= `LVL2_RST;
      kref_r <= `KREF_RST;
      scale_r <= `SCALE_RST;
      kpd_run_r <= 1'b0;
      kpd_rev_r <= 1'b0;
      di_prev_r <= 5'h00;
    end else begin
      di_prev_r <= di;
      if (!kpd_mode || !en_in) begin
        kpd_run_r <= 1'b0;
        kpd_rev_r <= 1'b0;
      // direct start ignores the stop key; only dropping enable or leaving keypad mode stops it
      end else if (direct) begin
        kpd_run_r <= 1'b1;
      end else if (kpd_stop) begin
        kpd_run_r <= 1'b0;
      end else if (kpd_start) begin
        kpd_run_r <= 1'b1;
        // start while running flips direction in two-way keypad
        if (kpd_run_r && mode == `M_KPD2) begin
          kpd_rev_r <= ~kpd_rev_r;
        end
      end
      if (kpd_start_ev && !ksb_r[1]) begin
        kref_r <= {DW{1'b0}};
      end else if (kpd_mode && (kpd_up || inc_edge)) begin
        kref_r <= step_ref(kref_r, 1'b1);
      end else if (kpd_mode && (kpd_down || dec_edge)) begin
        kref_r <= step_ref(kref_r, 1'b0);
      end
      // software writes land last so they win a same-cycle clash
      if (wr) begin
        case (paddr)
          `A_CFG: begin
            src_r <= pwdata[`CFG_SRC_LSB +: 3];
            mac_r <= pwdata[`CFG_MAC_LSB +: 5];
            auto_r <= pwdata[`CFG_AUTO_BIT];
            ksb_r <= {pwdata[`CFG_KEEP_BIT], pwdata[`CFG_DIRECT_BIT]};
          end
          `A_CODE: code_r <= pwdata[15:0];
          `A_LVL1: lvl1_r <= pwdata[15:0];
          `A_LVL2: lvl2_r <= pwdata[15:0];
          `A_KREF: kref_r <= pwdata[DW-1:0];
          `A_SCALE: scale_r <= pwdata[15:0];
          default: code_r <= code_r;
        endcase
      end
    end
  end

  // outputs; autostart block holds until the run request first drops or autostart is set
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      auto_blk_r <= 1'b1;
      run_cmd <= 1'b0;
      reverse_cmd <= 1'b0;
      speed_ref <= {DW{1'b0}};
      cmd_src <= 6'h01;
      ref_src <= 7'h01;
      op_blocked <= 1'b0;
      ext_menu <= 1'b0;
      adv_menu <= 1'b0;
      di_func <= 20'h00000;
      ai_func <= 8'h00;
    end else begin
      if (auto_r || !req_run) begin
        auto_blk_r <= 1'b0;
      end
      run_cmd <= run_nxt;
      reverse_cmd <= req_rev;
      speed_ref <= req_ref;
      cmd_src <= csel;
      ref_src <= sel;
      op_blocked <= blocked;
      ext_menu <= (code_r == lvl1_r) || (code_r == lvl2_r);
      adv_menu <= (code_r == lvl2_r);
      di_func <= dif;
      ai_func <= aif;
    end
  end
endmodule
`default_nettype wire

/* File: core/drive_ctl_defines.vh */
// Overview of operation
// - Source setting 0 takes run and stop from the terminals, speed from analog input 1 or 2 by select input, and terminal roles from the macro setting.
// - Source settings 1 (one direction) and 2 (both directions) run from the keypad start and stop keys with the keypad speed.
// - In keypad control the start-behaviour setting can make digital input 1 start the drive directly.
// - Source setting 3 takes run and stop from the terminal strip and speed from the PI controller output.
// - Source setting 4 takes commands and speed from a fitted fieldbus module, else from the Modbus RTU port.
// - Source settings 4, 5 and 6 block operation while digital input 1 is open, so the far side must hold it closed.
// - Source setting 5 copies the master's start, stop and frequency with the configured scaling.
// - Source setting 6 takes commands and speed over the CAN bus.
// - The menu code unlocks the extended menu when it equals the level-one code and the advanced group when it equals the level-two code.
// - The power-on autostart setting decides whether a run request present at power-up starts the drive.
// - In keypad mode the start-behaviour setting decides the start speed and whether enable alone starts the drive.
// - The macro setting picks from a fixed table the function of each digital terminal except input 1 outside terminal and PI control, which is the enable;
//   analog terminal roles follow the source setting.
`ifndef DRIVE_CTL_DEFINES_VH
`define DRIVE_CTL_DEFINES_VH
// register byte offsets
`define A_CFG 8'h00
`define A_CODE 8'h04
`define A_LVL1 8'h08
`define A_LVL2 8'h0c
`define A_KREF 8'h10
`define A_SCALE 8'h14
`define A_STAT 8'h18
`define A_TMAP 8'h1c
// configuration fields
`define CFG_SRC_LSB 0
`define CFG_MAC_LSB 8
`define CFG_AUTO_BIT 16
`define CFG_DIRECT_BIT 17
`define CFG_KEEP_BIT 18
// reset values and keypad reference step
`define SRC_RST 3'h0
`define MAC_RST 5'h01
`define AUTO_RST 1'b0
`define KSB_RST 2'h0
`define CODE_RST 16'h0000
`define LVL1_RST 16'h0065
`define LVL2_RST 16'h00c9
`define KREF_RST 16'h0000
`define SCALE_RST 16'h0100
`define KREF_STEP 16'h0010
// control source settings
`define M_TERM 3'h0
`define M_KPD1 3'h1
`define M_KPD2 3'h2
`define M_PI 3'h3
`define M_FB 3'h4
`define M_SLV 3'h5
`define M_CAN 3'h6
// one-hot select bit positions
`define S_AI 0
`define S_KPD 1
`define S_PI 2
`define S_OPT 3
`define S_MB 4
`define S_MST 5
`define S_CAN 6
// terminal function codes
`define F_NONE 4'h0
`define F_RUN_FWD 4'h1
`define F_RUN_REV 4'h2
`define F_STOP_NC 4'h3
`define F_DIR_REV 4'h4
`define F_AI2_SEL 4'h5
`define F_TRIP_NC 4'h6
`define F_INC 4'h7
`define F_DEC 4'h8
`define F_ENABLE 4'h9
`define F_AI_REF 4'h1
`define F_AI_FB 4'h2
`endif

/* File: core/input_macro_table.v */
`timescale 1ns/1ps
`default_nettype none
`include "drive_ctl_defines.vh"
module input_macro_table (
  input wire [4:0] macro,
  input wire [2:0] mode,
  output reg [19:0] di_func,
  output reg [7:0] ai_func
);
  // four bits per digital input, input 1 in the low nibble
  always @* begin
    ai_func = {`F_AI_REF, `F_AI_REF};
    case (macro)
      5'h00: di_func = {`F_NONE, `F_AI2_SEL, `F_DIR_REV, `F_NONE,
                        `F_RUN_FWD};
      5'h01: di_func = {`F_NONE, `F_AI2_SEL, `F_NONE, `F_RUN_REV,
                        `F_RUN_FWD};
      5'h02: di_func = {`F_NONE, `F_TRIP_NC, `F_STOP_NC, `F_RUN_REV,
                        `F_RUN_FWD};
      5'h03: di_func = {`F_NONE, `F_DEC, `F_INC, `F_DIR_REV,
                        `F_RUN_FWD};
      5'h04: di_func = {`F_NONE, `F_TRIP_NC, `F_AI2_SEL, `F_DIR_REV,
                        `F_RUN_FWD};
      default: di_func = {`F_NONE, `F_NONE, `F_NONE, `F_RUN_REV,
                          `F_RUN_FWD};
    endcase
    if (mode == `M_PI) begin
      ai_func = {`F_AI_FB, `F_AI_REF};
    end
    // outside terminal and PI control input 1 is the hardware enable
    if (mode != `M_TERM && mode != `M_PI) begin
      di_func[3:0] = `F_ENABLE;
    end
  end
endmodule
`default_nettype wire

/* File: test/drive_ctl_checker_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module drive_ctl_checker #(
  parameter DW = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [4:0] di,
  input wire logic [DW-1:0] pi_ref,
  input wire logic [DW-1:0] opt_ref,
  input wire logic [DW-1:0] can_ref,
  input wire logic [DW-1:0] speed_ref,
  input wire logic [5:0] cmd_src,
  input wire logic [6:0] ref_src,
  input wire logic run_cmd,
  input wire logic op_blocked,
  input wire logic ext_menu,
  input wire logic adv_menu
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_CMD_ONEHOT: assert property ($onehot(cmd_src))
    else $error("cmd_src not one-hot");
  AST_REF_ONEHOT: assert property ($onehot(ref_src))
    else $error("ref_src not one-hot");
  // the select seen one cycle later matches the mode the gate used
  AST_ENABLE_GATE: assert property (
    !di[0] ##1 (|cmd_src[5:2]) |-> op_blocked)
    else $error("open enable not blocking");
  AST_BLOCK_STOPS: assert property (op_blocked |-> !run_cmd)
    else $error("run while blocked");
  AST_PI_SPEED: assert property (
    ref_src[2] |-> speed_ref == $past(pi_ref))
    else $error("speed not from pi output");
  AST_OPT_SPEED: assert property (
    ref_src[3] |-> speed_ref == $past(opt_ref))
    else $error("speed not from option module");
  AST_CAN_SPEED: assert property (
    ref_src[6] |-> speed_ref == $past(can_ref))
    else $error("speed not from can bus");
  AST_ADV_HAS_EXT: assert property (adv_menu |-> ext_menu)
    else $error("advanced group without extended menu");
  cover property (run_cmd && cmd_src[2]);
  cover property (run_cmd && cmd_src[1]);
  cover property (adv_menu);
  cover property (pslverr);
endmodule
bind drive_control_source_selector drive_ctl_checker #(.DW(DW))
  drive_ctl_checker_i (.*);
`default_nettype wire

/* File: test/drive_far_side.sv */
`timescale 1ns/1ps
`default_nettype none
module drive_far_side (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] src,
  input wire logic run,
  input wire logic rev,
  input wire logic en,
  input wire logic [15:0] refv,
  output logic [4:0] di,
  output logic [111:0] refs,
  output logic [3:0] runs,
  output logic [3:0] revs
);
  logic [15:0] cnt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      cnt_r <= 16'h0000;
    else
      cnt_r <= cnt_r + 16'h0001;
  end
  // only input 1, the enable contact, is driven; selects stay open
  assign di = {4'h0, en};
  // idle sources carry a moving pattern so a wrong pick shows up
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      refs[i*16 +: 16] = (i == src) ? refv : cnt_r ^ 16'h5a5a;
    end
    for (int i = 0; i < 4; i++) begin
      runs[i] = (i + 3 == src) ? run : cnt_r[i];
      revs[i] = (i + 3 == src) ? rev : ~cnt_r[i];
    end
  end
endmodule
`default_nettype wire

/* File: test/test_drive_control_source_selector.sv */
`timescale 1ns/1ps
`default_nettype none
`include "drive_ctl_defines.vh"
module test_drive_control_source_selector;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, opt_present = 1'b1;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] kp = 4'h0;
  logic [2:0] src = 3'h0;
  logic run = 1'b0, rev = 1'b0, en = 1'b0;
  logic [15:0] refv = 16'h0;
  logic [31:0] prdata;
  logic pready, pslverr, run_cmd, reverse_cmd, op_blocked;
  logic ext_menu, adv_menu;
  logic [15:0] speed_ref;
  logic [5:0] cmd_src;
  logic [6:0] ref_src;
  logic [4:0] di;
  logic [111:0] refs;
  logic [3:0] runs, revs;
  logic [5:0] ecmd [9] = '{6'h01, 6'h02, 6'h02, 6'h01, 6'h04, 6'h10,
    6'h20, 6'h01, 6'h08};
  logic [6:0] eref [9] = '{7'h01, 7'h02, 7'h02, 7'h04, 7'h08, 7'h20,
    7'h40, 7'h01, 7'h10};
  logic [2:0] lsrc [9] = '{3'h0, 3'h0, 3'h0, 3'h2, 3'h3, 3'h5, 3'h6,
    3'h0, 3'h4};
  int errors = 0, num_checks = 0;
  drive_control_source_selector drive_control_source_selector_i (
    .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .di(di), .ai1_ref(refs[15:0]),
    .ai2_ref(refs[31:16]), .pi_ref(refs[47:32]), .kpd_start(kp[0]),
    .kpd_stop(kp[1]), .kpd_up(kp[2]), .kpd_down(kp[3]),
    .opt_present(opt_present), .opt_run(runs[0]), .opt_rev(revs[0]),
    .opt_ref(refs[63:48]), .mb_run(runs[1]), .mb_rev(revs[1]),
    .mb_ref(refs[79:64]), .mst_run(runs[2]), .mst_rev(revs[2]),
    .mst_ref(refs[95:80]), .can_run(runs[3]), .can_rev(revs[3]),
    .can_ref(refs[111:96]), .run_cmd(run_cmd), .reverse_cmd(reverse_cmd),
    .speed_ref(speed_ref), .cmd_src(cmd_src), .ref_src(ref_src),
    .op_blocked(op_blocked), .ext_menu(ext_menu), .adv_menu(adv_menu),
    .di_func(), .ai_func());
  drive_far_side drive_far_side_i (.clk(clk), .rst(rst), .src(src),
    .run(run), .rev(rev), .en(en), .refv(refv), .di(di), .refs(refs),
    .runs(runs), .revs(revs));
  initial forever #12.5 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] x,
      input logic [31:0] s);
    num_checks++;
    if (s !== x) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    int n = 0;
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    // registered answer is read mid-cycle, settled for the next edge
    @(negedge clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(negedge clk);
    end
    if (n == 50)
      errors++;
    q = prdata;
    e = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x,
      input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk("prdata", x, q);
    chk("pslverr", xe, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic key(input int k);
    @(posedge clk);
    kp <= 4'h1 << k;
    @(posedge clk);
    kp <= 4'h0;
    tick(3);
  endtask
  task automatic menu(input logic [31:0] c, input logic x, input logic y);
    wr(`A_CODE, c);
    tick(3);
    chk("ext_menu", x, ext_menu);
    chk("adv_menu", y, adv_menu);
  endtask
  task complete_run;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdc(`A_CFG, 32'h00000100, 1'b0);
    rdc(`A_CODE, 32'h0, 1'b0);
    rdc(`A_LVL1, 32'h00000065, 1'b0);
    rdc(`A_LVL2, 32'h000000c9, 1'b0);
    rdc(`A_SCALE, 32'h00000100, 1'b0);
    rdc(`A_TMAP, 32'h01105021, 1'b0);
    rdc(8'h20, 32'h0, 1'b1);
    $display("reset test done");
    en <= 1'b1;
    for (int m = 0; m < 9; m++) begin
      opt_present <= (m != 8);
      src <= lsrc[m];
      refv <= 16'h1230 + 16'(m);
      wr(`A_CFG, (m == 8) ? 4 : m);
      tick(3);
      chk("cmd_src", ecmd[m], cmd_src);
      chk("ref_src", eref[m], ref_src);
      if (m != 1 && m != 2)
        chk("speed_ref", 16'h1230 + 16'(m), speed_ref);
    end
    $display("source test done");
    opt_present <= 1'b1;
    run <= 1'b1;
    for (int m = 4; m < 7; m++) begin
      src <= lsrc[m];
      en <= 1'b0;
      rev <= 1'b0;
      wr(`A_CFG, m);
      tick(3);
      chk("op_blocked", 1'b1, op_blocked);
      chk("run_cmd", 1'b0, run_cmd);
      en <= 1'b1;
      rev <= 1'b1;
      tick(3);
      chk("run_cmd", 1'b1, run_cmd);
      chk("reverse_cmd", 1'b1, reverse_cmd);
    end
    src <= 3'h5;
    refv <= 16'h1000;
    wr(`A_CFG, `M_SLV);
    wr(`A_SCALE, 32'h00000080);
    tick(3);
    chk("speed_ref", 16'h0800, speed_ref);
    $display("gate test done");
    run <= 1'b0;
    rev <= 1'b0;
    wr(`A_CFG, `M_KPD1);
    tick(3);
    chk("run_cmd", 1'b0, run_cmd);
    key(0);
    chk("run_cmd", 1'b1, run_cmd);
    key(1);
    chk("run_cmd", 1'b0, run_cmd);
    wr(`A_KREF, 32'h00000100);
    key(2);
    rdc(`A_KREF, 32'h00000110, 1'b0);
    en <= 1'b0;
    wr(`A_CFG, 32'h00020001);
    tick(3);
    en <= 1'b1;
    tick(3);
    chk("run_cmd", 1'b1, run_cmd);
    en <= 1'b0;
    tick(3);
    chk("run_cmd", 1'b0, run_cmd);
    wr(`A_CFG, `M_KPD2);
    en <= 1'b1;
    key(0);
    chk("reverse_cmd", 1'b0, reverse_cmd);
    key(0);
    chk("reverse_cmd", 1'b1, reverse_cmd);
    rdc(`A_TMAP, 32'h01105409, 1'b0);
    $display("keypad test done");
    menu(32'h00000065, 1'b1, 1'b0);
    menu(32'h000000c9, 1'b1, 1'b1);
    menu(32'h0, 1'b0, 1'b0);
    wr(`A_LVL1, 32'h00000033);
    menu(32'h00000033, 1'b1, 1'b0);
    $display("menu test done");
    en <= 1'b1;
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(3);
    chk("run_cmd", 1'b0, run_cmd);
    en <= 1'b0;
    tick(3);
    en <= 1'b1;
    tick(3);
    chk("run_cmd", 1'b1, run_cmd);
    $display("autostart test done");
    complete_run();
  end
endmodule
`default_nettype wire
